// File: core/ufmc_pkg.sv
// Constants, register map, field layouts and state encodings of the serial frame block.
package ufmc_pkg;

	localparam int          ADDR_W     = 12;
	localparam logic [11:0] OFS_DATA   = 12'h0f40;
	localparam logic [11:0] OFS_STAT   = 12'h0f41;
	localparam logic [11:0] OFS_CTL0   = 12'h0f42;
	localparam logic [11:0] OFS_CTL1   = 12'h0f43;
	localparam logic [11:0] OFS_STAT2  = 12'h0f44;
	localparam logic [11:0] OFS_ADDRC  = 12'h0f45;
	localparam logic [11:0] OFS_DIVH   = 12'h0f46;
	localparam logic [11:0] OFS_DIVL   = 12'h0f47;

	localparam logic [7:0]  CTL0_RST   = 8'h00;
	localparam logic [7:0]  CTL1_RST   = 8'h00;
	localparam logic [7:0]  ADDRC_RST  = 8'h00;
	localparam logic [15:0] DIV_RST    = 16'h0001;

	// Oversampling: sixteen baud ticks per bit, mid-bit sample, infrared pulse width.
	localparam logic [3:0]  SUB_LAST   = 4'hf;
	localparam logic [3:0]  SUB_MID    = 4'h7;
	localparam logic [3:0]  IR_PULSE   = 4'h3;
	localparam logic [4:0]  IR_STRETCH = 5'h10;
	localparam logic [2:0]  BIT_LAST   = 3'h7;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} ufmc_bus_t;

	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic spare;
		logic parity_en;
		logic parity_odd;
		logic force_line_low;
		logic two_stop;
		logic internal_loopback_enable;
	} ufmc_ctl0_t;

	typedef struct packed {
		logic scheme_hi;
		logic nine_bit_mode_enable;
		logic scheme_lo;
		logic ninth_bit_value;
		logic driver_enable_polarity;
		logic rate_generator_control;
		logic rx_data_irq_select;
		logic infrared_codec_enable;
	} ufmc_ctl1_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_START = 3'h1,
		TX_DATA  = 3'h3,
		TX_NINTH = 3'h2,
		TX_PAR   = 3'h6,
		TX_STOP1 = 3'h7,
		TX_STOP2 = 3'h5
	} ufmc_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h3,
		RX_EXTRA = 3'h2,
		RX_STOP  = 3'h6
	} ufmc_rx_st_t;

endpackage : ufmc_pkg

// File: core/ufmc_top.sv
// Serial transmitter, receiver, baud generator, multidrop filter and infrared codec.
`timescale 1ns/1ps
module ufmc_top (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Register port
	input  wire ufmc_pkg::ufmc_bus_t bus,
	output logic [7:0]              rdata,
	// Line side
	output logic                    tx_pin,
	input  wire logic               rx_pin,
	output logic                    driver_enable,
	// Requests
	output logic                    rx_irq_req,
	output logic                    tx_irq_req,
	output logic                    timer_expired
);
	import ufmc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	ufmc_ctl0_t    ctl0_r,    ctl0_nxt;
	ufmc_ctl1_t    ctl1_r,    ctl1_nxt;
	logic [7:0]    addrc_r,   addrc_nxt;
	logic [15:0]   div_r,     div_nxt;
	logic [7:0]    rdata_r,   rdata_nxt;
	logic [15:0]   cnt_r,     cnt_nxt;
	logic          tmr_r,     tmr_nxt;
	logic          tick;
	logic          timer_mode;
	logic          wr_data,   rd_data;

	ufmc_tx_st_t   tx_st_r,   tx_st_nxt;
	logic [7:0]    hold_r,    hold_nxt;
	logic          hfull_r,   hfull_nxt;
	logic [7:0]    tsh_r,     tsh_nxt;
	logic [3:0]    tsub_r,    tsub_nxt;
	logic [2:0]    tbit_r,    tbit_nxt;
	logic          tpar_r,    tpar_nxt;
	logic          tnin_r,    tnin_nxt;
	logic          tser_r,    tser_nxt;
	logic          tpin_r,    tpin_nxt;
	logic          de_r,      de_nxt;
	logic          tirq_r,    tirq_nxt;

	ufmc_rx_st_t   rx_st_r,   rx_st_nxt;
	logic [3:0]    rsub_r,    rsub_nxt;
	logic [2:0]    rbit_r,    rbit_nxt;
	logic [7:0]    rsh_r,     rsh_nxt;
	logic          rpar_r,    rpar_nxt;
	logic          rx_r,      rx_nxt;
	logic          rprev_r,   rprev_nxt;
	logic [4:0]    ird_r,     ird_nxt;
	logic [7:0]    rbuf_r,    rbuf_nxt;
	logic          rnin_r,    rnin_nxt;
	logic          avail_r,   avail_nxt;
	logic          perr_r,    perr_nxt;
	logic          ovr_r,     ovr_nxt;
	logic          ferr_r,    ferr_nxt;
	logic          brk_r,     brk_nxt;
	logic          match_r,   match_nxt;
	logic          rreq_r,    rreq_nxt;
	logic          rline;
	logic          done;
	logic          c_ferr,    c_perr,   c_brk;
	logic          is_addr,   hit,      qual;

	////////////////////////////////////////////////////////////////////////////
	// Register port and baud generator.
	assign wr_data    = bus.wr && (bus.addr == OFS_DATA);
	assign rd_data    = bus.rd && (bus.addr == OFS_DATA);
	assign tick       = (cnt_r <= 16'h0001);
	assign timer_mode = ctl1_r.rate_generator_control && !ctl0_r.rx_en;

	always_comb begin
		ctl0_nxt  = ctl0_r;
		ctl1_nxt  = ctl1_r;
		addrc_nxt = addrc_r;
		div_nxt   = div_r;
		cnt_nxt   = tick ? div_r : cnt_r - 16'h0001;
		// A new expiry in the cycle of the clearing read keeps the flag set.
		tmr_nxt   = (tmr_r && !(bus.rd && bus.addr == OFS_STAT2)) || (timer_mode && tick);
		rdata_nxt = 8'h00;
		if (bus.wr) begin
			case (bus.addr)
				OFS_CTL0:  ctl0_nxt  = bus.wdata;
				OFS_CTL1:  ctl1_nxt  = bus.wdata;
				OFS_ADDRC: addrc_nxt = bus.wdata;
				OFS_DIVH:  div_nxt   = {bus.wdata, div_r[7:0]};
				OFS_DIVL: begin
					div_nxt = {div_r[15:8], bus.wdata};
					cnt_nxt = {div_r[15:8], bus.wdata};
				end
				default:   ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				OFS_DATA:  rdata_nxt = rbuf_r;
				OFS_STAT:  rdata_nxt = {avail_r, perr_r, ovr_r, ferr_r, brk_r, !hfull_r,
				                        (tx_st_r == TX_IDLE) && !hfull_r, rnin_r};
				OFS_CTL0:  rdata_nxt = ctl0_r;
				OFS_CTL1:  rdata_nxt = ctl1_r;
				OFS_STAT2: rdata_nxt = {7'h00, tmr_r};
				OFS_ADDRC: rdata_nxt = addrc_r;
				// In timer mode the live count is visible instead of the reload value.
				OFS_DIVH:  rdata_nxt = timer_mode ? cnt_r[15:8] : div_r[15:8];
				OFS_DIVL:  rdata_nxt = timer_mode ? cnt_r[7:0] : div_r[7:0];
				default:   rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl0_r  <= CTL0_RST;
			ctl1_r  <= CTL1_RST;
			addrc_r <= ADDRC_RST;
			div_r   <= DIV_RST;
			cnt_r   <= DIV_RST;
			tmr_r   <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ctl0_r  <= ctl0_nxt;
			ctl1_r  <= ctl1_nxt;
			addrc_r <= addrc_nxt;
			div_r   <= div_nxt;
			cnt_r   <= cnt_nxt;
			tmr_r   <= tmr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter. The oversampling phase runs even when idle so that a forced
	// low line still produces regular infrared pulses.
	always_comb begin
		tx_st_nxt = tx_st_r;
		hold_nxt  = hold_r;
		hfull_nxt = hfull_r;
		tsh_nxt   = tsh_r;
		tsub_nxt  = tick ? tsub_r + 4'h1 : tsub_r;
		tbit_nxt  = tbit_r;
		tpar_nxt  = tpar_r;
		tnin_nxt  = tnin_r;
		tser_nxt  = tser_r;
		if (tick && tsub_r == SUB_LAST) begin
			case (tx_st_r)
				TX_START: begin
					tx_st_nxt = TX_DATA;
					tbit_nxt  = 3'h0;
					tser_nxt  = tsh_r[0];
				end
				TX_DATA: begin
					tpar_nxt = tpar_r ^ tsh_r[0];
					tsh_nxt  = {1'b0, tsh_r[7:1]};
					tbit_nxt = tbit_r + 3'h1;
					tser_nxt = tsh_r[1];
					if (tbit_r == BIT_LAST) begin
						if (ctl1_r.nine_bit_mode_enable) begin
							tx_st_nxt = TX_NINTH;
							tser_nxt  = tnin_r;
						end else if (ctl0_r.parity_en) begin
							tx_st_nxt = TX_PAR;
							tser_nxt  = tpar_r ^ tsh_r[0];
						end else begin
							tx_st_nxt = TX_STOP1;
							tser_nxt  = 1'b1;
						end
					end
				end
				TX_NINTH, TX_PAR: begin
					tx_st_nxt = TX_STOP1;
					tser_nxt  = 1'b1;
				end
				TX_STOP1: tx_st_nxt = ctl0_r.two_stop ? TX_STOP2 : TX_IDLE;
				TX_STOP2: tx_st_nxt = TX_IDLE;
				default:  tser_nxt  = 1'b1;
			endcase
		end
		if (tx_st_r == TX_IDLE && hfull_r && ctl0_r.tx_en && !ctl0_r.force_line_low) begin
			tx_st_nxt = TX_START;
			tsh_nxt   = hold_r;
			hfull_nxt = 1'b0;
			tsub_nxt  = 4'h0;
			tpar_nxt  = ctl0_r.parity_odd;
			tnin_nxt  = ctl1_r.ninth_bit_value;
			tser_nxt  = 1'b0;
		end else if (tx_st_r == TX_IDLE && !ctl0_r.force_line_low) begin
			tser_nxt = 1'b1;
		end
		if (ctl0_r.force_line_low) begin
			// The character in flight is abandoned, not resumed on release.
			tx_st_nxt = TX_IDLE;
			tser_nxt  = 1'b0;
		end
		if (wr_data) begin
			hold_nxt  = bus.wdata;
			hfull_nxt = 1'b1;
		end
		// Zero bits become a short high pulse, one bits send nothing.
		if (ctl0_r.internal_loopback_enable)
			tpin_nxt = 1'b1;
		else if (ctl1_r.infrared_codec_enable)
			tpin_nxt = !tser_r && (tsub_r < IR_PULSE);
		else
			tpin_nxt = tser_r;
		de_nxt   = ((tx_st_r != TX_IDLE) || hfull_r) ^ ctl1_r.driver_enable_polarity;
		tirq_nxt = ctl0_r.tx_en && !hfull_r;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r <= TX_IDLE;
			hold_r  <= 8'h00;
			hfull_r <= 1'b0;
			tsh_r   <= 8'h00;
			tsub_r  <= 4'h0;
			tbit_r  <= 3'h0;
			tpar_r  <= 1'b0;
			tnin_r  <= 1'b0;
			tser_r  <= 1'b1;
			tpin_r  <= 1'b1;
			de_r    <= 1'b0;
			tirq_r  <= 1'b0;
		end else begin
			tx_st_r <= tx_st_nxt;
			hold_r  <= hold_nxt;
			hfull_r <= hfull_nxt;
			tsh_r   <= tsh_nxt;
			tsub_r  <= tsub_nxt;
			tbit_r  <= tbit_nxt;
			tpar_r  <= tpar_nxt;
			tnin_r  <= tnin_nxt;
			tser_r  <= tser_nxt;
			tpin_r  <= tpin_nxt;
			de_r    <= de_nxt;
			tirq_r  <= tirq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver, infrared decoder and multidrop filter.
	assign rline   = ctl0_r.internal_loopback_enable ? tser_r
	               : ctl1_r.infrared_codec_enable ? (!rx_pin && ird_r == 5'h00)
	               : rx_pin;
	assign done    = (rx_st_r == RX_STOP) && tick && (rsub_r == SUB_LAST);
	assign c_ferr  = !rline;
	assign c_perr  = ctl0_r.parity_en && !ctl1_r.nine_bit_mode_enable
	               && ((rpar_r ^ rx_r) != ctl0_r.parity_odd);
	assign c_brk   = !rline && (rsh_r == 8'h00)
	               && !((ctl0_r.parity_en || ctl1_r.nine_bit_mode_enable) && rx_r);
	assign is_addr = ctl1_r.nine_bit_mode_enable && rx_r;
	assign hit     = (rsh_r == addrc_r);

	always_comb begin
		case ({ctl1_r.scheme_hi, ctl1_r.scheme_lo})
			2'b00:   qual = 1'b1;
			2'b01:   qual = is_addr;
			2'b10:   qual = is_addr ? hit : match_r;
			default: qual = !is_addr && match_r;
		endcase
		if (!ctl1_r.nine_bit_mode_enable)
			qual = 1'b1;
	end

	always_comb begin
		rx_st_nxt = rx_st_r;
		rsub_nxt  = tick ? rsub_r + 4'h1 : rsub_r;
		rbit_nxt  = rbit_r;
		rsh_nxt   = rsh_r;
		rpar_nxt  = rpar_r;
		rx_nxt    = rx_r;
		rprev_nxt = rline;
		// A received pulse holds the decoded line low for one full bit time.
		ird_nxt   = rx_pin ? IR_STRETCH : (tick && ird_r != 5'h00) ? ird_r - 5'h01 : ird_r;
		case (rx_st_r)
			RX_IDLE: begin
				if (ctl0_r.rx_en && rprev_r && !rline) begin
					rx_st_nxt = RX_START;
					rsub_nxt  = 4'h0;
				end
			end
			RX_START: begin
				if (tick && rsub_r == SUB_MID) begin
					rx_st_nxt = rline ? RX_IDLE : RX_DATA;
					rsub_nxt  = 4'h0;
					rbit_nxt  = 3'h0;
					rpar_nxt  = 1'b0;
					rx_nxt    = 1'b0;
				end
			end
			RX_DATA: begin
				if (tick && rsub_r == SUB_LAST) begin
					rsh_nxt  = {rline, rsh_r[7:1]};
					rpar_nxt = rpar_r ^ rline;
					rbit_nxt = rbit_r + 3'h1;
					if (rbit_r == BIT_LAST)
						rx_st_nxt = (ctl0_r.parity_en || ctl1_r.nine_bit_mode_enable) ? RX_EXTRA
						          : RX_STOP;
				end
			end
			RX_EXTRA: begin
				if (tick && rsub_r == SUB_LAST) begin
					rx_nxt    = rline;
					rx_st_nxt = RX_STOP;
				end
			end
			RX_STOP:  if (done) rx_st_nxt = RX_IDLE;
			default:  rx_st_nxt = RX_IDLE;
		endcase
		if (!ctl0_r.rx_en)
			rx_st_nxt = RX_IDLE;
	end

	// Reading data clears the flags, but a character completing in the same
	// cycle sets them again; its own flags are never lost.
	always_comb begin
		rbuf_nxt  = rbuf_r;
		rnin_nxt  = rnin_r;
		avail_nxt = avail_r && !rd_data;
		perr_nxt  = perr_r && !rd_data;
		ovr_nxt   = ovr_r && !rd_data;
		ferr_nxt  = ferr_r && !rd_data;
		brk_nxt   = brk_r && !rd_data;
		match_nxt = match_r;
		rreq_nxt  = rreq_r && !rd_data;
		if (done) begin
			if (is_addr)
				match_nxt = hit;
			if (avail_r && !rd_data) begin
				// The unread character is kept; the new one is dropped.
				ovr_nxt  = 1'b1;
				rreq_nxt = rreq_r || !ctl1_r.rx_data_irq_select;
			end else begin
				rbuf_nxt  = rsh_r;
				rnin_nxt  = is_addr;
				avail_nxt = 1'b1;
				perr_nxt  = perr_nxt || c_perr;
				ferr_nxt  = ferr_nxt || c_ferr;
				brk_nxt   = brk_nxt || c_brk;
				rreq_nxt  = rreq_nxt || qual
				         || (!ctl1_r.rx_data_irq_select && (c_perr || c_ferr || c_brk));
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= RX_IDLE;
			rsub_r  <= 4'h0;
			rbit_r  <= 3'h0;
			rsh_r   <= 8'h00;
			rpar_r  <= 1'b0;
			rx_r    <= 1'b0;
			rprev_r <= 1'b1;
			ird_r   <= 5'h00;
			rbuf_r  <= 8'h00;
			rnin_r  <= 1'b0;
			avail_r <= 1'b0;
			perr_r  <= 1'b0;
			ovr_r   <= 1'b0;
			ferr_r  <= 1'b0;
			brk_r   <= 1'b0;
			match_r <= 1'b0;
			rreq_r  <= 1'b0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rsub_r  <= rsub_nxt;
			rbit_r  <= rbit_nxt;
			rsh_r   <= rsh_nxt;
			rpar_r  <= rpar_nxt;
			rx_r    <= rx_nxt;
			rprev_r <= rprev_nxt;
			ird_r   <= ird_nxt;
			rbuf_r  <= rbuf_nxt;
			rnin_r  <= rnin_nxt;
			avail_r <= avail_nxt;
			perr_r  <= perr_nxt;
			ovr_r   <= ovr_nxt;
			ferr_r  <= ferr_nxt;
			brk_r   <= brk_nxt;
			match_r <= match_nxt;
			rreq_r  <= rreq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign rdata         = rdata_r;
	assign tx_pin        = tpin_r;
	assign driver_enable = de_r;
	assign rx_irq_req    = rreq_r;
	assign tx_irq_req    = tirq_r;
	assign timer_expired = tmr_r;

endmodule : ufmc_top

// File: tb/ufmc_chk.sv
// Port-level assertions for the serial frame block, bound into its top module.
`timescale 1ns/1ps
module ufmc_chk (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rst_n,
	// Register port
	input wire ufmc_pkg::ufmc_bus_t bus,
	input wire logic [7:0]          rdata,
	// Line side and requests
	input wire logic                tx_pin,
	input wire logic                driver_enable,
	input wire logic                timer_expired
);
	import ufmc_pkg::*;
	// Shadows of the control writes, since the block's registers are not visible here.
	logic [7:0]  ctl0_r;
	logic [7:0]  ctl1_r;
	logic [15:0] div_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl0_r <= CTL0_RST;
			ctl1_r <= CTL1_RST;
			div_r  <= DIV_RST;
		end else if (bus.wr) begin
			if (bus.addr == OFS_CTL0)
				ctl0_r <= bus.wdata;
			if (bus.addr == OFS_CTL1)
				ctl1_r <= bus.wdata;
			if (bus.addr == OFS_DIVH)
				div_r[15:8] <= bus.wdata;
			if (bus.addr == OFS_DIVL)
				div_r[7:0] <= bus.wdata;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_unmapped_read: assert property ($past(bus.rd) && ($past(bus.addr) < OFS_DATA
		|| $past(bus.addr) > OFS_DIVL) |-> rdata == 8'h00)
		else $error("unmapped read returned nonzero data");
	a_ctl1_readback: assert property ($past(bus.rd) && $past(bus.addr) == OFS_CTL1
		|-> rdata == ctl1_r) else $error("second control register readback wrong");
	a_break_low: assert property (ctl0_r[2] && $past(ctl0_r[2], 2)
		&& !ctl0_r[0] && !ctl1_r[0] |-> !tx_pin) else $error("line not held low");
	a_loop_high: assert property (ctl0_r[0] && $past(ctl0_r[0], 2) |-> tx_pin)
		else $error("transmit pin moved during loopback");
	a_drive_on_send: assert property (bus.wr && bus.addr == OFS_DATA && ctl0_r[7]
		&& !ctl0_r[2] |-> ##[1:3] driver_enable != ctl1_r[3])
		else $error("driver enable not raised for a character");
	a_ir_pulse: assert property (ctl1_r[0] && !ctl0_r[0] && !ctl0_r[2]
		&& div_r <= 16'h0001 && $rose(tx_pin) |-> tx_pin[*3] ##1 !tx_pin)
		else $error("infrared pulse not three sub-ticks wide");
	a_timer_mode: assert property ($rose(timer_expired)
		|-> $past(ctl1_r[2]) && !$past(ctl0_r[6])) else $error("timer flag outside timer mode");
endmodule : ufmc_chk

bind ufmc_top ufmc_chk u_chk (.ref_clk, .rst_n, .bus, .rdata, .tx_pin, .driver_enable,
	.timer_expired);

// File: tb/ufmc_node.sv
// Remote serial node model facing the transmit and receive pins.
`timescale 1ns/1ps
module ufmc_node (
	// Clock
	input  wire logic ref_clk,
	// Line side
	input  wire logic tx_pin,
	output logic      rx_pin
);
	initial rx_pin = 1'b1;
	// Sends n bits of f, first bit first; infrared gives a 3-clock pulse per zero bit.
	// Timing assumes a divisor of one, so a bit lasts sixteen clocks.
	task automatic send(input logic [11:0] f, input int n, input logic ir);
		for (int i = 0; i < n; i++) begin
			for (int s = 0; s < 16; s++) begin
				@(posedge ref_clk) rx_pin <= ir ? (!f[i] && s < 3) : f[i];
			end
		end
		@(posedge ref_clk) rx_pin <= !ir;
		repeat (16) @(posedge ref_clk);
	endtask : send
	// Waits for a start bit, then samples n bits at their middles.
	task automatic recv(input int n, output logic [11:0] f);
		f = '0;
		while (tx_pin !== 1'b0) @(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			f[i] = tx_pin;
			repeat (16) @(posedge ref_clk);
		end
	endtask : recv
	// Counts clocks until the next start bit appears.
	task automatic gap(output int c);
		c = 0;
		while (tx_pin !== 1'b0) begin
			@(posedge ref_clk);
			c++;
		end
	endtask : gap
endmodule : ufmc_node

// File: tb/ufmc_top_test.sv
// Self-checking bench: registers, frames, errors, multidrop, break, infrared, timer.
`timescale 1ns/1ps
module ufmc_top_test;
	import ufmc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	ufmc_bus_t   bus     = '0;
	logic [7:0]  rdata;
	logic        tx_pin;
	logic        rx_pin;
	logic        driver_enable;
	logic        rx_irq_req;
	logic        tx_irq_req;
	logic        timer_expired;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          g;
	logic [7:0]  v;
	logic [11:0] f;
	// Receive cases: good, parity error, framing error, break, overrun.
	logic [11:0] rx_fr [5] = '{12'h0466, 12'h0666, 12'h0066, 12'h0000, 12'h0466};
	logic [7:0]  rx_st [5] = '{8'h80, 8'hc0, 8'h90, 8'h98, 8'ha0};
	// Multidrop stream: matching address, data, other address, data.
	logic [11:0] md_fr [4] = '{12'h0624, 12'h04aa, 12'h0668, 12'h04cc};
	logic [3:0]  md_irq [4] = '{4'b1111, 4'b0101, 4'b0011, 4'b0010};
	always #25 ref_clk = ~ref_clk;
	ufmc_top u_dut (.ref_clk, .rst_n, .bus, .rdata, .tx_pin, .rx_pin, .driver_enable,
		.rx_irq_req, .tx_irq_req, .timer_expired);
	ufmc_node u_node (.ref_clk, .tx_pin, .rx_pin);
	////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus <= '0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		@(posedge ref_clk);
		d = rdata;
	endtask : rd
	task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
		rd(a, v);
		chk(12'(v), 12'(exp));
	endtask : rchk
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// The whole run needs under ten thousand clocks.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rchk(OFS_CTL1, CTL1_RST);
		wr(OFS_CTL1, 8'h5a);
		rchk(OFS_CTL1, 8'h5a);
		wr(OFS_CTL1, 8'h00);
		rchk(12'h0f4f, 8'h00);
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CTL0, k ? 8'hda : 8'hd0);
			wr(OFS_DATA, 8'ha7);
			wr(OFS_DATA, 8'h3c);
			u_node.recv(10, f);
			chk(f, {2'b00, !k[0], 8'ha7, 1'b0});
			// The second character still waits in the holding register here.
			chk(12'(tx_irq_req), 12'h000);
			u_node.gap(g);
			chk(12'(g >= 8 + 16 * k && g < 24 + 16 * k), 12'h001);
			chk(12'(tx_irq_req), 12'h001);
			u_node.recv(10, f);
			chk(f, {2'b00, k[0], 8'h3c, 1'b0});
			repeat (40) @(posedge ref_clk);
		end
		$display("test transmit frames done");
		wr(OFS_CTL0, 8'hd1);
		wr(OFS_DATA, 8'h5e);
		repeat (200) @(posedge ref_clk);
		chk(12'(rx_irq_req), 12'h001);
		rchk(OFS_DATA, 8'h5e);
		@(posedge ref_clk);
		chk(12'(rx_irq_req), 12'h000);
		$display("test loopback done");
		wr(OFS_CTL0, 8'hd0);
		for (int i = 0; i < 5; i++) begin
			u_node.send(rx_fr[i], 11, 1'b0);
			if (i == 4)
				u_node.send(rx_fr[i], 11, 1'b0);
			rd(OFS_STAT, v);
			chk(12'(v & 8'hf8), 12'(rx_st[i]));
			rchk(OFS_DATA, rx_fr[i][8:1]);
		end
		$display("test receive errors done");
		wr(OFS_CTL0, 8'hc0);
		wr(OFS_ADDRC, 8'h12);
		wr(OFS_CTL1, 8'h50);
		wr(OFS_DATA, 8'h81);
		u_node.recv(10, f);
		chk(f, 12'h0302);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTL1, {s[1], 1'b1, s[0], 5'h00});
			for (int j = 0; j < 4; j++) begin
				u_node.send(md_fr[j], 11, 1'b0);
				chk(12'(rx_irq_req), 12'(md_irq[s][j]));
				rchk(OFS_DATA, md_fr[j][8:1]);
			end
		end
		// A data character with a bad stop bit: only the error can raise the request.
		for (int q = 0; q < 2; q++) begin
			wr(OFS_CTL1, q ? 8'h62 : 8'h60);
			u_node.send(12'h00aa, 11, 1'b0);
			chk(12'(rx_irq_req), 12'(!q[0]));
			rchk(OFS_DATA, 8'h55);
		end
		// Inverted driver-enable polarity for the break test.
		wr(OFS_CTL1, 8'h08);
		$display("test multidrop done");
		wr(OFS_CTL0, 8'h80);
		wr(OFS_DATA, 8'hff);
		repeat (40) @(posedge ref_clk);
		chk(12'(driver_enable), 12'h000);
		wr(OFS_CTL0, 8'h84);
		repeat (160) @(posedge ref_clk);
		chk(12'(tx_pin), 12'h000);
		wr(OFS_CTL0, 8'h80);
		repeat (4) @(posedge ref_clk);
		chk(12'(tx_pin), 12'h001);
		chk(12'(driver_enable), 12'h001);
		$display("test break done");
		wr(OFS_CTL1, 8'h01);
		u_node.send(12'h000, 0, 1'b1);
		wr(OFS_DATA, 8'h0f);
		g = 0;
		repeat (200) begin
			@(posedge ref_clk);
			g += tx_pin;
		end
		chk(12'(g), 12'h00f);
		wr(OFS_CTL0, 8'hc0);
		u_node.send(12'h02b4, 10, 1'b1);
		rchk(OFS_DATA, 8'h5a);
		wr(OFS_CTL0, 8'h00);
		wr(OFS_CTL1, 8'h00);
		u_node.send(12'h000, 0, 1'b0);
		$display("test infrared done");
		wr(OFS_DIVH, 8'h00);
		wr(OFS_DIVL, 8'h20);
		wr(OFS_CTL1, 8'h04);
		g = 0;
		while (timer_expired !== 1'b1 && g < 100) begin
			@(posedge ref_clk);
			g++;
		end
		chk(12'(timer_expired), 12'h001);
		rchk(OFS_STAT2, 8'h01);
		@(posedge ref_clk);
		chk(12'(timer_expired), 12'h000);
		$display("test timer done");
		test_done();
	end
endmodule : ufmc_top_test
